// file: bench/overheat_monitor_props.sv
// checker for the overheat monitor, watching only the top module's ports
// assumes one clock domain and the word-addressed register map of the package
`default_nettype none

module overheat_monitor_props import overheat_pkg::*; #(
  parameter int unsigned TICK_CYCLES = FILTER_STEP_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // sense side
  input wire logic signed [15:0] overheat_sense_input,
  input wire logic sense_line_fault,
  input wire logic signed [15:0] motor_warn_threshold,
  input wire logic signed [15:0] motor_alarm_threshold,
  // results
  input wire logic overheat_warning_event,
  input wire logic overheat_alarm_event,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] picked, mode;
  logic [2:0] age;
  logic took, settled, mo;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a write lands at the edge that sees waitrequest low
  assign took = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign settled = age == 3'h7;
  assign mo = settled && mode == SRC_MOTOR;
  // mirror the active mode; age gives the output pipeline time to drain
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      picked <= 2'h0;
      mode <= 2'h0;
      age <= 3'h0;
    end else begin
      if (took && avs_address == REG_SOURCE_SELECT) begin
        picked <= avs_writedata[1:0];
      end
      if (took && avs_address == REG_CONTROL && avs_writedata[0]) begin
        mode <= picked;
        age <= 3'h0;
      end else if (!settled) begin
        age <= age + 3'h1;
      end
    end
  end
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer held over one cycle");
  property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("request not answered next cycle");
  property p_off_quiet; settled && mode == SRC_OFF |-> !overheat_warning_event && !overheat_alarm_event; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("event while protection off");
  property p_motor_alarm;
    (mo && overheat_sense_input > motor_alarm_threshold)[*3] |-> overheat_alarm_event; endproperty
  a_motor_alarm: assert property (p_motor_alarm) else $error("motor alarm missing");
  property p_motor_warn_off;
    (mo && !sense_line_fault && overheat_sense_input <= motor_warn_threshold)[*3] |-> !overheat_warning_event;
  endproperty
  a_motor_warn_off: assert property (p_motor_warn_off) else $error("motor warning below threshold");
  property p_motor_fault; (mo && sense_line_fault)[*3] |-> overheat_alarm_event; endproperty
  a_motor_fault: assert property (p_motor_fault) else $error("motor line fault not alarmed");
  property p_neg_fault;
    (settled && mode == SRC_MACHINE_NEG && sense_line_fault)[*3] |-> overheat_alarm_event; endproperty
  a_neg_fault: assert property (p_neg_fault) else $error("negative mode line fault not alarmed");
  property p_pos_fault;
    (settled && mode == SRC_MACHINE_POS && sense_line_fault && overheat_sense_input <= 0)[*3]
      |-> !overheat_alarm_event; endproperty
  a_pos_fault: assert property (p_pos_fault) else $error("positive mode alarmed on line fault");
  c_motor_alarm: cover property (mo && overheat_alarm_event);
  c_neg_fault: cover property (settled && mode == SRC_MACHINE_NEG && sense_line_fault && overheat_alarm_event);
  c_irq: cover property ($rose(irq));
endmodule

bind overheat_protection_monitor overheat_monitor_props #(.TICK_CYCLES(TICK_CYCLES)) props_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .overheat_sense_input(overheat_sense_input),
  .sense_line_fault(sense_line_fault), .motor_warn_threshold(motor_warn_threshold),
  .motor_alarm_threshold(motor_alarm_threshold), .overheat_warning_event(overheat_warning_event),
  .overheat_alarm_event(overheat_alarm_event), .irq(irq));

`default_nettype wire

// file: bench/overheat_protection_monitor_test.sv
// self-checking bench for the overheat protection monitor
// assumes the sensor model and the bound checker are compiled before it
`default_nettype none

module overheat_protection_monitor_test import overheat_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICKS = 10;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, sense_line_fault, overheat_warning_event, overheat_alarm_event, irq;
  logic signed [15:0] overheat_sense_input, motor_warn_threshold, motor_alarm_threshold;
  logic signed [15:0] want_value = 16'sh0000;
  logic want_fault = 1'b0;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  // filter second shortened to TICKS cycles
  overheat_protection_monitor #(.TICK_CYCLES(TICKS)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .overheat_sense_input(overheat_sense_input), .sense_line_fault(sense_line_fault),
    .motor_warn_threshold(motor_warn_threshold), .motor_alarm_threshold(motor_alarm_threshold),
    .overheat_warning_event(overheat_warning_event), .overheat_alarm_event(overheat_alarm_event), .irq(irq));
  sense_source_model #(.WARN_THR(16'sh0050), .ALARM_THR(16'sh0078)) sensor_u (.ref_clk(ref_clk),
    .want_value(want_value), .want_fault(want_fault), .overheat_sense_input(overheat_sense_input),
    .sense_line_fault(sense_line_fault), .motor_warn_threshold(motor_warn_threshold),
    .motor_alarm_threshold(motor_alarm_threshold));

  // 200 MHz clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // a hang counts as a mismatch and ends the run
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one avalon transfer; entered just after an edge, leaves one edge idle
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // only the bench timeout ends this wait
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic set_mode(input logic [31:0] m);
    wr(REG_SOURCE_SELECT, m);
    wr(REG_CONTROL, 32'h1);
  endtask
  // the sense path settles within six edges, filter off
  task automatic drive(input logic signed [15:0] v, input logic f);
    want_value <= v;
    want_fault <= f;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic outs(input logic w, input logic a);
    chk({30'h0, overheat_warning_event, overheat_alarm_event}, {30'h0, w, a});
  endtask

  task automatic t_reset();
    rd(REG_SOURCE_SELECT, 32'h0);
    rd(REG_ALARM_LEVEL, 32'h0fa);
    rd(REG_WARN_PERCENT, 32'h64);
    rd(REG_FILTER_SECONDS, 32'h0);
    rd(4'hf, 32'h0);
    wr(REG_ALARM_LEVEL, 32'h258);
    rd(REG_ALARM_LEVEL, 32'h1f4);
    wr(REG_WARN_PERCENT, 32'h96);
    rd(REG_WARN_PERCENT, 32'h64);
    wr(REG_FILTER_SECONDS, 32'hffff);
    rd(REG_FILTER_SECONDS, 32'hffff);
  endtask
  // local level zero would alarm a machine mode after the five filter seconds; motor mode must not care
  task automatic t_motor();
    wr(REG_ALARM_LEVEL, 32'h0);
    wr(REG_WARN_PERCENT, 32'h0);
    wr(REG_FILTER_SECONDS, 32'h5);
    wr(REG_SOURCE_SELECT, 32'h1);
    rd(REG_LIVE_STATUS, 32'h0);
    wr(REG_CONTROL, 32'h1);
    drive(16'sd80, 1'b0);
    outs(1'b0, 1'b0);
    rd(REG_LIVE_STATUS, 32'h1);
    drive(16'sd81, 1'b0);
    outs(1'b1, 1'b0);
    drive(16'sd121, 1'b0);
    outs(1'b1, 1'b1);
    drive(16'sd50, 1'b1);
    chk(32'(overheat_alarm_event), 32'h1);
  endtask
  task automatic t_negative();
    wr(REG_ALARM_LEVEL, 32'h0fa);
    wr(REG_WARN_PERCENT, 32'h50);
    wr(REG_FILTER_SECONDS, 32'h0);
    wr(REG_EVENT_ENABLE, 32'h7);
    set_mode(32'h2);
    drive(-16'sd200, 1'b0);
    outs(1'b0, 1'b0);
    drive(-16'sd210, 1'b0);
    outs(1'b1, 1'b0);
    drive(-16'sd251, 1'b0);
    outs(1'b1, 1'b1);
    rd(REG_SENSE_VALUE, 32'hff05);
    chk(32'(irq), 32'h1);
    drive(16'sd300, 1'b0);
    outs(1'b0, 1'b0);
    drive(16'sd0, 1'b1);
    chk(32'(overheat_alarm_event), 32'h1);
    drive(16'sd0, 1'b0);
    rd(REG_EVENT_STATUS, 32'h7);
    wr(REG_EVENT_CLEAR, 32'h7);
    rd(REG_EVENT_STATUS, 32'h0);
    chk(32'(irq), 32'h0);
    // one filter second is TICKS cycles of unbroken over-level
    wr(REG_FILTER_SECONDS, 32'h1);
    drive(-16'sd300, 1'b0);
    chk(32'(overheat_alarm_event), 32'h0);
    repeat (7) @(posedge ref_clk);
    chk(32'(overheat_alarm_event), 32'h0);
    @(posedge ref_clk);
    chk(32'(overheat_alarm_event), 32'h1);
  endtask
  task automatic t_positive();
    wr(REG_FILTER_SECONDS, 32'h0);
    set_mode(32'h3);
    drive(16'sd0, 1'b1);
    // hold the fault long enough for the checker to see it
    repeat (6) @(posedge ref_clk);
    chk(32'(overheat_alarm_event), 32'h0);
    drive(16'sd300, 1'b0);
    outs(1'b1, 1'b1);
    rd(REG_LIVE_STATUS, 32'hf);
    rd(REG_SENSE_VALUE, 32'h12c);
    wr(REG_EVENT_ENABLE, 32'h0);
    wr(REG_EVENT_CLEAR, 32'h7);
    rd(REG_EVENT_STATUS, 32'h3);
    chk(32'(irq), 32'h0);
    wr(REG_EVENT_ENABLE, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h1);
  endtask
  task automatic t_off();
    set_mode(32'h0);
    drive(-16'sd400, 1'b1);
    outs(1'b0, 1'b0);
    wr(REG_EVENT_CLEAR, 32'h7);
    rd(REG_EVENT_STATUS, 32'h0);
  endtask

  // reset for five cycles, then the scenarios in turn
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_motor();
    t_negative();
    t_positive();
    t_off();
    wrap_up();
  end
endmodule

`default_nettype wire

// file: bench/sense_source_model.sv
// far side of the monitor: motor thermal protector or machine sensor
// assumes the bench asks for a reading and a line state after each edge
`default_nettype none

module sense_source_model #(
  parameter logic signed [15:0] WARN_THR = 16'sh0050,
  parameter logic signed [15:0] ALARM_THR = 16'sh0078
) (
  // clock
  input wire logic ref_clk,
  // requested reading
  input wire logic signed [15:0] want_value,
  input wire logic want_fault,
  // sensor side
  output logic signed [15:0] overheat_sense_input,
  output logic sense_line_fault,
  output logic signed [15:0] motor_warn_threshold,
  output logic signed [15:0] motor_alarm_threshold
);
  timeunit 1ns;
  timeprecision 1ps;
  // thresholds live in the motor, fixed for the run
  assign motor_warn_threshold = WARN_THR;
  assign motor_alarm_threshold = ALARM_THR;
  // the sensor converts once per cycle, so a new reading shows one edge late
  always_ff @(posedge ref_clk) begin
    overheat_sense_input <= want_value;
    sense_line_fault <= want_fault;
  end
endmodule

`default_nettype wire

// file: rtl/overheat_pkg.sv
// constants, field layouts and types of the overheat protection monitor
// assumes one 200 MHz clock and an avalon-mm word-addressed register slave
// Function
// - selection 1 takes motor thermal protector input
// - motor mode: warn above motor warning temperature
// - motor mode: alarm above motor alarm temperature
// - motor mode: open or shorted line alarms
// - motor mode ignores local levels and filter
// - selections 2, 3 watch machine sensor voltage
// - alarm level 0..500, 0.01 V, default 250
// - warning level 0..100 percent, default 100
// - filter time 0..65535 seconds, default 0
// - negative machine mode alarms on line fault
// - positive machine mode ignores line fault; no alarm here, but the fault event and live status bit still set
// - selection codes 0..3, applied on restart
`default_nettype none

package overheat_pkg;

  // clock and filter timing
  localparam int CLK_HZ = 200_000_000;
  localparam int FILTER_STEP_S = 1;
  localparam int FILTER_STEP_CYCLES = FILTER_STEP_S * CLK_HZ;

  // setting ranges and reset values
  localparam logic [8:0] ALARM_LEVEL_MAX = 9'h1f4;
  localparam logic [8:0] ALARM_LEVEL_RESET = 9'h0fa;
  localparam logic [6:0] WARN_PCT_MAX = 7'h64;
  localparam logic [6:0] WARN_PCT_RESET = 7'h64;
  localparam logic [15:0] FILTER_SEC_RESET = 16'h0000;
  localparam logic [6:0] PERCENT_FULL = 7'h64;

  // register indices; byte address is four times the index
  localparam logic [3:0] REG_SOURCE_SELECT = 4'h0;
  localparam logic [3:0] REG_ALARM_LEVEL = 4'h1;
  localparam logic [3:0] REG_WARN_PERCENT = 4'h2;
  localparam logic [3:0] REG_FILTER_SECONDS = 4'h3;
  localparam logic [3:0] REG_CONTROL = 4'h4;
  localparam logic [3:0] REG_LIVE_STATUS = 4'h5;
  localparam logic [3:0] REG_EVENT_STATUS = 4'h6;
  localparam logic [3:0] REG_EVENT_ENABLE = 4'h7;
  localparam logic [3:0] REG_EVENT_CLEAR = 4'h8;
  localparam logic [3:0] REG_SENSE_VALUE = 4'h9;

  // control register fields
  localparam int CTRL_RESTART_BIT = 0;

  // live status fields
  localparam int LIVE_ACTIVE_LSB = 0;
  localparam int LIVE_WARN_BIT = 2;
  localparam int LIVE_ALARM_BIT = 3;
  localparam int LIVE_FAULT_BIT = 4;

  // event bits, shared by status, enable and clear
  localparam int EVENT_COUNT = 3;
  localparam int EV_WARN_BIT = 0;
  localparam int EV_ALARM_BIT = 1;
  localparam int EV_FAULT_BIT = 2;
  localparam logic [2:0] EVENT_RESET = 3'h0;

  // overheat source selection codes
  typedef enum logic [1:0] {
    SRC_OFF = 2'h0,
    SRC_MOTOR = 2'h1,
    SRC_MACHINE_NEG = 2'h2,
    SRC_MACHINE_POS = 2'h3
  } source_t;

  // bus answer sequence
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;

endpackage

`default_nettype wire

// file: rtl/overheat_protection_monitor.sv
// overheat protection monitor: sense input evaluation, settings and events
// assumes sense and motor threshold inputs are synchronous to ref_clk, and an
// avalon-mm master with waitrequest on the register port
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`default_nettype none

module overheat_protection_monitor import overheat_pkg::*; #(
  parameter int unsigned TICK_CYCLES = FILTER_STEP_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // avalon-mm register slave, word addressed
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // sense front end
  input wire logic signed [15:0] overheat_sense_input,
  input wire logic sense_line_fault,
  // thresholds held in the motor, same units as the sense input
  input wire logic signed [15:0] motor_warn_threshold,
  input wire logic signed [15:0] motor_alarm_threshold,
  // results
  output logic overheat_warning_event,
  output logic overheat_alarm_event,
  output logic irq
);

  // limits a user must know:
  //   inputs count as synchronous
  //   the line fault gets no debounce
  //   selection waits for a restart
  //   level compares are strict
  //   a filter second is TICK_CYCLES clocks

  // registers by word index:
  //   0 source select, pending
  //   1 alarm level, 500 at most
  //   2 warning percent, 100 at most
  //   3 filter seconds
  //   4 control, bit 0 restarts
  //   5 live status
  //   6 sticky event status
  //   7 event enable
  //   8 event clear, one clears
  //   9 last sense sample
  // unmapped words read zero
  // control and clear read zero

  typedef struct packed {
    bus_state_t bus;
    logic waitrequest;
    logic [31:0] readdata;
    source_t select;
    logic [8:0] alarm_level;
    logic [6:0] warn_pct;
    logic [15:0] filter_sec;
    source_t active;
    logic signed [15:0] sense;
    logic fault;
    logic warning;
    logic alarm;
    logic [2:0] ev_status;
    logic [2:0] ev_enable;
    logic irq;
  } state_t;

  state_t s;
  state_t next_s;

  // merge a write into a register under the byte enables
  // disabled lanes keep their old bytes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_value, input logic [31:0] wdata,
                                              input logic [3:0] be);
    logic [31:0] result;
    result = old_value;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        result[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return result;
  endfunction

  // out of range settings are held at the top of their range
  // clamped on write, so compares need no check
  function automatic logic [15:0] clamp_setting(input logic [31:0] value, input logic [15:0] top);
    logic [15:0] result;
    result = top;
    if (value <= {16'h0, top}) begin
      result = value[15:0];
    end
    return result;
  endfunction

  // magnitude of the sensor voltage in the polarity the mode watches;
  // the wrong polarity reads as zero so it can never trip
  // negated -32768 needs bit 16
  function automatic logic [16:0] machine_magnitude(input source_t mode, input logic signed [15:0] v);
    logic [16:0] result;
    logic signed [16:0] wide;
    result = 17'h0;
    wide = 17'(v);
    if (mode == SRC_MACHINE_NEG && v < 0) begin
      result = 17'(-wide);
    end else if (mode == SRC_MACHINE_POS && v > 0) begin
      result = 17'(wide);
    end
    return result;
  endfunction

  // combinational view of the sense evaluation
  logic machine_mode;
  logic [16:0] magnitude;
  logic [23:0] scaled_sense;
  logic [23:0] scaled_limit;
  logic machine_over_level;
  logic machine_over_warn;
  logic filter_expired;
  logic next_warning;
  logic next_alarm;
  logic bus_request;
  logic bus_commit;
  logic [31:0] merged;
  logic [31:0] read_mux;

  // mode decode uses the applied selection, never the pending one
  assign machine_mode = (s.active == SRC_MACHINE_NEG) || (s.active == SRC_MACHINE_POS);

  // the machine comparisons use only the local settings
  assign magnitude = machine_magnitude(s.active, s.sense);
  assign machine_over_level = machine_mode && (magnitude > {8'h0, s.alarm_level});

  // compare mag*100 against level*pct so no divider is needed
  // 32768 * 100 fits 24 bits easily
  assign scaled_sense = 24'(magnitude) * 24'(PERCENT_FULL);
  assign scaled_limit = 24'(s.alarm_level) * 24'(s.warn_pct);
  assign machine_over_warn = machine_mode && (scaled_sense > scaled_limit);

  // motor mode never arms the timer, so
  // the local filter cannot alarm it
  // filter timer restarts whenever the voltage drops back inside the level
  persist_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_filter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .armed(machine_over_level),
    .limit_seconds(s.filter_sec),
    .expired(filter_expired)
  );

  // warning and alarm per mode; the disabled mode raises nothing
  always_comb begin
    next_warning = 1'b0;
    next_alarm = 1'b0;
    case (s.active)
      SRC_MOTOR: begin
        // thresholds come from the motor; local settings play no part
        next_warning = (s.sense > motor_warn_threshold);
        next_alarm = (s.sense > motor_alarm_threshold)
                     || s.fault;
      end
      SRC_MACHINE_NEG: begin
        // line fault alarms past the filter
        next_warning = machine_over_warn;
        next_alarm = (machine_over_level && filter_expired)
                     || s.fault;
      end
      SRC_MACHINE_POS: begin
        // a broken or shorted line reads as no voltage here, so it raises no alarm; the fault bits still record it
        next_warning = machine_over_warn;
        next_alarm = machine_over_level && filter_expired;
      end
      default: begin
        // off or unknown: raise nothing
        next_warning = 1'b0;
        next_alarm = 1'b0;
      end
    endcase
  end

  // bus answer by edge:
  //   e0  request and read data taken
  //   e1  waitrequest seen low, write lands
  //   e2  idle, next request welcome
  // no error answer, no burst

  // a request is taken while waitrequest is high and committed one edge later
  // writes land where waitrequest is seen low
  assign bus_request = avs_read || avs_write;
  assign bus_commit = (s.bus == BUS_ANSWER) && avs_write;

  // register read view, captured when the request is taken
  // newer values in the wait cycle are missed
  always_comb begin
    read_mux = 32'h0;
    case (avs_address)
      REG_SOURCE_SELECT: read_mux = {30'h0, s.select};
      REG_ALARM_LEVEL: read_mux = {23'h0, s.alarm_level};
      REG_WARN_PERCENT: read_mux = {25'h0, s.warn_pct};
      REG_FILTER_SECONDS: read_mux = {16'h0, s.filter_sec};
      REG_LIVE_STATUS: begin
        read_mux[LIVE_ACTIVE_LSB +: 2] = s.active;
        read_mux[LIVE_WARN_BIT] = s.warning;
        read_mux[LIVE_ALARM_BIT] = s.alarm;
        read_mux[LIVE_FAULT_BIT] = s.fault;
      end
      REG_EVENT_STATUS: read_mux = {29'h0, s.ev_status};
      REG_EVENT_ENABLE: read_mux = {29'h0, s.ev_enable};
      REG_SENSE_VALUE: read_mux = {16'h0, s.sense};
      default: read_mux = 32'h0; // control, clear and unmapped read as zero
    endcase
  end

  // write data merged over the current value of the addressed register
  always_comb begin
    merged = 32'h0;
    case (avs_address)
      REG_SOURCE_SELECT: merged = merge_bytes({30'h0, s.select}, avs_writedata, avs_byteenable);
      REG_ALARM_LEVEL: merged = merge_bytes({23'h0, s.alarm_level}, avs_writedata, avs_byteenable);
      REG_WARN_PERCENT: merged = merge_bytes({25'h0, s.warn_pct}, avs_writedata, avs_byteenable);
      REG_FILTER_SECONDS: merged = merge_bytes({16'h0, s.filter_sec}, avs_writedata, avs_byteenable);
      REG_EVENT_ENABLE: merged = merge_bytes({29'h0, s.ev_enable}, avs_writedata, avs_byteenable);
      default: merged = merge_bytes(32'h0, avs_writedata, avs_byteenable);
    endcase
  end

  // edges after an input change:
  //   n    sample registered
  //   n+1  motor outputs, line fault
  //   n+1  zero filter expires
  //   n+2  machine alarm
  // each filter second adds TICK_CYCLES
  // a dip below the level restarts

  // next state of the whole block
  always_comb begin
    next_s = s;

    // sample the front end once so every comparison sees the same value
    // an idle block records no fault
    next_s.sense = overheat_sense_input;
    next_s.fault = (s.active != SRC_OFF) && sense_line_fault;
    next_s.warning = next_warning;
    next_s.alarm = next_alarm;

    // bus sequence: take, then answer with waitrequest low for one cycle
    // a request held past e1 is taken
    // again as a second transfer
    case (s.bus)
      BUS_IDLE: begin
        if (bus_request) begin
          next_s.bus = BUS_ANSWER;
          next_s.waitrequest = 1'b0;
          next_s.readdata = avs_read ? read_mux : 32'h0;
        end
      end
      BUS_ANSWER: begin
        next_s.bus = BUS_IDLE;
        next_s.waitrequest = 1'b1;
      end
      default: begin
        next_s.bus = BUS_IDLE;
        next_s.waitrequest = 1'b1;
      end
    endcase

    // settings take effect on the commit edge
    if (bus_commit) begin
      case (avs_address)
        REG_SOURCE_SELECT: next_s.select = source_t'(merged[1:0]);
        REG_ALARM_LEVEL: next_s.alarm_level = 9'(clamp_setting(merged, {7'h0, ALARM_LEVEL_MAX}));
        REG_WARN_PERCENT: next_s.warn_pct = 7'(clamp_setting(merged, {9'h0, WARN_PCT_MAX}));
        REG_FILTER_SECONDS: next_s.filter_sec = merged[15:0];
        REG_CONTROL: begin
          // a new selection only applies at restart
          if (avs_byteenable[0] && avs_writedata[CTRL_RESTART_BIT]) begin
            next_s.active = s.select;
          end
        end
        REG_EVENT_ENABLE: next_s.ev_enable = merged[2:0];
        REG_EVENT_CLEAR: begin
          if (avs_byteenable[0]) begin
            next_s.ev_status = s.ev_status & ~avs_writedata[2:0];
          end
        end
        default: next_s.ev_status = next_s.ev_status; // unmapped or read-only: ignored
      endcase
    end

    // sticky events; a set in the clear cycle wins
    // a lasting cause sets its bit again,
    // so clear only after removing it
    if (next_warning) begin
      next_s.ev_status[EV_WARN_BIT] = 1'b1;
    end
    if (next_alarm) begin
      next_s.ev_status[EV_ALARM_BIT] = 1'b1;
    end
    if (next_s.fault) begin
      next_s.ev_status[EV_FAULT_BIT] = 1'b1;
    end

    // level interrupt from the enabled sticky bits
    next_s.irq = |(next_s.ev_status & next_s.ev_enable);
  end

  // reset drops any pending selection
  // all state but the filter timer (u_filter) in one register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s.bus <= BUS_IDLE;
      s.waitrequest <= 1'b1;
      s.readdata <= 32'h0;
      s.select <= SRC_OFF;
      s.alarm_level <= ALARM_LEVEL_RESET;
      s.warn_pct <= WARN_PCT_RESET;
      s.filter_sec <= FILTER_SEC_RESET;
      s.active <= SRC_OFF;
      s.sense <= 16'sh0;
      s.fault <= 1'b0;
      s.warning <= 1'b0;
      s.alarm <= 1'b0;
      s.ev_status <= EVENT_RESET;
      s.ev_enable <= EVENT_RESET;
      s.irq <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  // no pin is fed by logic alone
  assign avs_readdata = s.readdata;
  assign avs_waitrequest = s.waitrequest;
  assign overheat_warning_event = s.warning;
  assign overheat_alarm_event = s.alarm;
  assign irq = s.irq;

endmodule

`default_nettype wire

// file: rtl/persist_timer.sv
// counts whole seconds for which a condition has held without a break
// assumes the caller holds armed low to restart the count
`default_nettype none

module persist_timer import overheat_pkg::*; #(
  parameter int unsigned TICK_CYCLES = FILTER_STEP_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // condition and limit
  input wire logic armed,
  input wire logic [15:0] limit_seconds,
  // result
  output logic expired
);

  typedef struct packed {
    logic [31:0] prescale;
    logic [15:0] seconds;
    logic expired;
  } timer_t;

  timer_t s;
  timer_t next_s;

  // any break in the condition throws the count away
  always_comb begin
    next_s = s;
    if (!armed) begin
      next_s.prescale = 32'h0;
      next_s.seconds = 16'h0;
      next_s.expired = 1'b0;
    end else begin
      if (s.prescale == 32'(TICK_CYCLES - 1)) begin
        next_s.prescale = 32'h0;
        if (s.seconds != 16'hffff) begin
          next_s.seconds = s.seconds + 16'h1; // saturates, so a 65535 s limit still ends
        end
      end else begin
        next_s.prescale = s.prescale + 32'h1;
      end
      next_s.expired = (next_s.seconds >= limit_seconds);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign expired = s.expired;

endmodule

`default_nettype wire
